// [radio_task_event_defines.svh]
// Offsets, field positions and reset values of the radio task and event bank.
// Assumes an APB slave with 32-bit data, one aligned word per register.
// Behaviour
// - Stop task halts ongoing transmit or receive
// - Disable task shuts radio out of enabled
// - Strength start task takes exactly one sample
// - Strength stop task ends running measurement
// - Bit counter start task starts counting bits
// - Bit counter stop task halts bit counter
// - Ramp done flag set after ramp-up, resets zero
// - Address flag set when address sent/received
// - Payload flag set when payload sent/received
// - Packet done flag set when packet complete
`ifndef RADIO_TASK_EVENT_DEFINES_SVH
`define RADIO_TASK_EVENT_DEFINES_SVH

`define RTE_ADDR_W              12
`define RTE_OFF_START           12'h008
`define RTE_OFF_STOP            12'h00c
`define RTE_OFF_DISABLE         12'h010
`define RTE_OFF_SAMPLE_START    12'h014
`define RTE_OFF_SAMPLE_STOP     12'h018
`define RTE_OFF_BC_START        12'h01c
`define RTE_OFF_BC_STOP         12'h020
`define RTE_OFF_RAMP_DONE       12'h100
`define RTE_OFF_ADDRESS         12'h104
`define RTE_OFF_PAYLOAD         12'h108
`define RTE_OFF_PACKET_DONE     12'h10c
`define RTE_OFF_IRQ_MASK        12'h304
`define RTE_OFF_IRQ_STATUS      12'h308
`define RTE_OFF_CORE_STATE      12'h400

`define RTE_TRIGGER_BIT         0
`define RTE_EVENT_BIT           0
`define RTE_NUM_EVENTS          4
`define RTE_EV_RAMP_DONE        0
`define RTE_EV_ADDRESS          1
`define RTE_EV_PAYLOAD          2
`define RTE_EV_PACKET_DONE      3
`define RTE_ST_RAMPED           0
`define RTE_ST_ACTIVE           1
`define RTE_ST_SAMPLING         2
`define RTE_ST_COUNTING         3
`define RTE_RESET_VALUE         32'h0000_0000

`endif

// [radio_task_event_pkg.sv]
// Types shared by the radio task and event bank.
// Assumes the defines header is compiled alongside.
package radio_task_event_pkg;

    typedef enum logic [1:0] {
        RADIO_OFF,
        RADIO_RAMPED,
        RADIO_ACTIVE
    } radio_mode_t;

    typedef struct packed {
        logic        flag;
    } flag_state_t;

    typedef struct packed {
        radio_mode_t mode;
        logic        sampling;
        logic        counting;
        logic [3:0]  irq_mask;
        logic [3:0]  irq_status;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        start_pulse;
        logic        stop_pulse;
        logic        disable_pulse;
        logic        sample_start_pulse;
        logic        sample_stop_pulse;
        logic        bc_start_pulse;
        logic        bc_stop_pulse;
    } bank_state_t;

endpackage : radio_task_event_pkg

// [radio_event_flag.sv]
// One sticky event flag of the bank.
// Assumes set and write strobes are synchronous one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module radio_event_flag
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Hardware event and software write
    input  wire logic set_in,
    input  wire logic wr_en,
    input  wire logic wr_bit,
    // Flag
    output var  logic flag
);

    radio_task_event_pkg::flag_state_t state_reg;
    radio_task_event_pkg::flag_state_t state_next;

    // A hardware event in the cycle of a software write wins
    always_comb
    begin
        state_next = state_reg;
        if (wr_en)
        begin
            state_next.flag = wr_bit;
        end
        if (set_in)
        begin
            state_next.flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

endmodule : radio_event_flag

`default_nettype wire

// [radio_task_event_registers.sv]
// Task and event register bank of the packet radio, APB slave.
// Assumes the radio core gives one-cycle event pulses on sys_clk and
// accepts one-cycle task pulses; interconnect task inputs are pulses too.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "radio_task_event_defines.svh"

module radio_task_event_registers
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Task triggers from the event interconnect
    input  wire logic        ic_start,
    input  wire logic        ic_stop,
    input  wire logic        ic_disable,
    input  wire logic        ic_sample_start,
    input  wire logic        ic_sample_stop,
    input  wire logic        ic_bc_start,
    input  wire logic        ic_bc_stop,
    // Events from the radio core
    input  wire logic        core_ramp_done,
    input  wire logic        core_address,
    input  wire logic        core_payload,
    input  wire logic        core_packet_done,
    input  wire logic        core_sample_done,
    // Task pulses to the radio core
    output var  logic        radio_start,
    output var  logic        radio_stop,
    output var  logic        radio_disable,
    output var  logic        strength_sample_start,
    output var  logic        strength_sample_stop,
    output var  logic        bit_counter_start,
    output var  logic        bit_counter_stop,
    // Core state and interrupt
    output var  logic        radio_enabled,
    output var  logic        radio_running,
    output var  logic        sampling_busy,
    output var  logic        bit_counter_running,
    output var  logic        irq
);

    radio_task_event_pkg::bank_state_t state_reg;
    radio_task_event_pkg::bank_state_t state_next;

    logic                         setup_phase;
    logic                         write_taken;
    logic [`RTE_NUM_EVENTS-1:0]   event_in;
    logic [`RTE_NUM_EVENTS-1:0]   event_flag;
    logic [`RTE_NUM_EVENTS-1:0]   event_wr;
    logic                         wr_trigger;
    logic                         start_req;
    logic                         stop_req;
    logic                         disable_req;
    logic                         sample_start_req;
    logic                         sample_stop_req;
    logic                         bc_start_req;
    logic                         bc_stop_req;
    logic                         addr_mapped;
    logic [31:0]                  read_value;
    logic [3:0]                   core_state;

    assign setup_phase = psel && !penable;
    // The write lands on the edge where the master sees pready high
    assign write_taken = psel && penable && pwrite && state_reg.pready;
    assign wr_trigger  = pwdata[`RTE_TRIGGER_BIT];

    assign event_in[`RTE_EV_RAMP_DONE]   = core_ramp_done;
    assign event_in[`RTE_EV_ADDRESS]     = core_address;
    assign event_in[`RTE_EV_PAYLOAD]     = core_payload;
    assign event_in[`RTE_EV_PACKET_DONE] = core_packet_done;

    // Software writes of trigger value or interconnect pulses request tasks
    assign start_req = ic_start
        || (write_taken && paddr == `RTE_OFF_START && wr_trigger);
    assign stop_req = ic_stop
        || (write_taken && paddr == `RTE_OFF_STOP && wr_trigger);
    assign disable_req = ic_disable
        || (write_taken && paddr == `RTE_OFF_DISABLE && wr_trigger);
    assign sample_start_req = ic_sample_start
        || (write_taken && paddr == `RTE_OFF_SAMPLE_START && wr_trigger);
    assign sample_stop_req = ic_sample_stop
        || (write_taken && paddr == `RTE_OFF_SAMPLE_STOP && wr_trigger);
    assign bc_start_req = ic_bc_start
        || (write_taken && paddr == `RTE_OFF_BC_START && wr_trigger);
    assign bc_stop_req = ic_bc_stop
        || (write_taken && paddr == `RTE_OFF_BC_STOP && wr_trigger);

    // Event flags: written value stored, hardware event wins
    genvar gi;
    generate
        for (gi = 0; gi < `RTE_NUM_EVENTS; gi = gi + 1)
        begin : g_event
            assign event_wr[gi] = write_taken
                && paddr == (`RTE_OFF_RAMP_DONE + 12'(4 * gi));

            radio_event_flag u_flag
            (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .set_in  (event_in[gi]),
                .wr_en   (event_wr[gi]),
                .wr_bit  (pwdata[`RTE_EVENT_BIT]),
                .flag    (event_flag[gi])
            );
        end
    endgenerate

    assign core_state[`RTE_ST_RAMPED]   = state_reg.mode != radio_task_event_pkg::RADIO_OFF;
    assign core_state[`RTE_ST_ACTIVE]   = state_reg.mode == radio_task_event_pkg::RADIO_ACTIVE;
    assign core_state[`RTE_ST_SAMPLING] = state_reg.sampling;
    assign core_state[`RTE_ST_COUNTING] = state_reg.counting;

    // Address decode and read mux; task registers are write only
    always_comb
    begin
        addr_mapped = 1'b1;
        read_value  = `RTE_RESET_VALUE;
        unique case (paddr)
            `RTE_OFF_START,
            `RTE_OFF_STOP,
            `RTE_OFF_DISABLE,
            `RTE_OFF_SAMPLE_START,
            `RTE_OFF_SAMPLE_STOP,
            `RTE_OFF_BC_START,
            `RTE_OFF_BC_STOP:
            begin
                read_value = `RTE_RESET_VALUE;
            end
            `RTE_OFF_RAMP_DONE:
            begin
                read_value[`RTE_EVENT_BIT] = event_flag[`RTE_EV_RAMP_DONE];
            end
            `RTE_OFF_ADDRESS:
            begin
                read_value[`RTE_EVENT_BIT] = event_flag[`RTE_EV_ADDRESS];
            end
            `RTE_OFF_PAYLOAD:
            begin
                read_value[`RTE_EVENT_BIT] = event_flag[`RTE_EV_PAYLOAD];
            end
            `RTE_OFF_PACKET_DONE:
            begin
                read_value[`RTE_EVENT_BIT] = event_flag[`RTE_EV_PACKET_DONE];
            end
            `RTE_OFF_IRQ_MASK:
            begin
                read_value[3:0] = state_reg.irq_mask;
            end
            `RTE_OFF_IRQ_STATUS:
            begin
                read_value[3:0] = state_reg.irq_status;
            end
            `RTE_OFF_CORE_STATE:
            begin
                read_value[3:0] = core_state;
            end
            default:
            begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        state_next = state_reg;

        // Bus answer: pready high for one access cycle after setup
        state_next.pready  = setup_phase;
        state_next.pslverr = setup_phase && !addr_mapped;
        if (setup_phase)
        begin
            state_next.prdata = pwrite ? `RTE_RESET_VALUE : read_value;
        end

        state_next.start_pulse        = 1'b0;
        state_next.stop_pulse         = 1'b0;
        state_next.disable_pulse      = 1'b0;
        state_next.sample_start_pulse = 1'b0;
        state_next.sample_stop_pulse  = 1'b0;
        state_next.bc_start_pulse     = 1'b0;
        state_next.bc_stop_pulse      = 1'b0;

        // Radio mode; disable overrides stop, stop overrides start
        unique case (state_reg.mode)
            radio_task_event_pkg::RADIO_OFF:
            begin
                if (core_ramp_done && !disable_req)
                begin
                    state_next.mode = radio_task_event_pkg::RADIO_RAMPED;
                end
            end
            radio_task_event_pkg::RADIO_RAMPED:
            begin
                if (disable_req)
                begin
                    state_next.mode = radio_task_event_pkg::RADIO_OFF;
                end
                else if (start_req && !stop_req)
                begin
                    state_next.mode        = radio_task_event_pkg::RADIO_ACTIVE;
                    state_next.start_pulse = 1'b1;
                end
            end
            radio_task_event_pkg::RADIO_ACTIVE:
            begin
                if (disable_req)
                begin
                    state_next.mode = radio_task_event_pkg::RADIO_OFF;
                end
                else if (stop_req || core_packet_done)
                begin
                    state_next.mode = radio_task_event_pkg::RADIO_RAMPED;
                end
            end
            // The fourth code of the mode field is never used
            default:
            begin
                state_next.mode = radio_task_event_pkg::RADIO_OFF;
            end
        endcase

        if (stop_req && !disable_req)
        begin
            state_next.stop_pulse = 1'b1;
        end
        if (disable_req)
        begin
            state_next.disable_pulse = 1'b1;
        end

        // One-shot strength sample: busy until sample done, stop or disable
        if (sample_stop_req || disable_req)
        begin
            state_next.sampling          = 1'b0;
            state_next.sample_stop_pulse = state_reg.sampling;
        end
        else if (sample_start_req && !state_reg.sampling)
        begin
            state_next.sampling           = 1'b1;
            state_next.sample_start_pulse = 1'b1;
        end
        else if (core_sample_done)
        begin
            state_next.sampling = 1'b0;
        end

        // Bit counter run state
        if (bc_stop_req || disable_req)
        begin
            state_next.counting       = 1'b0;
            state_next.bc_stop_pulse  = 1'b1;
        end
        else if (bc_start_req)
        begin
            state_next.counting       = 1'b1;
            state_next.bc_start_pulse = 1'b1;
        end

        // Interrupt status: write one clears, a new event wins
        if (write_taken && paddr == `RTE_OFF_IRQ_MASK)
        begin
            state_next.irq_mask = pwdata[3:0];
        end
        if (write_taken && paddr == `RTE_OFF_IRQ_STATUS)
        begin
            state_next.irq_status = state_reg.irq_status & ~pwdata[3:0];
        end
        state_next.irq_status = state_next.irq_status | event_in;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg      <= '0;
            state_reg.mode <= radio_task_event_pkg::RADIO_OFF;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign prdata                = state_reg.prdata;
    assign pready                = state_reg.pready;
    assign pslverr               = state_reg.pslverr;
    assign radio_start           = state_reg.start_pulse;
    assign radio_stop            = state_reg.stop_pulse;
    assign radio_disable         = state_reg.disable_pulse;
    assign strength_sample_start = state_reg.sample_start_pulse;
    assign strength_sample_stop  = state_reg.sample_stop_pulse;
    assign bit_counter_start     = state_reg.bc_start_pulse;
    assign bit_counter_stop      = state_reg.bc_stop_pulse;
    assign radio_enabled         = state_reg.mode != radio_task_event_pkg::RADIO_OFF;
    assign radio_running         = state_reg.mode == radio_task_event_pkg::RADIO_ACTIVE;
    assign sampling_busy         = state_reg.sampling;
    assign bit_counter_running   = state_reg.counting;
    assign irq                   = state_reg.irq;

endmodule : radio_task_event_registers

`default_nettype wire

// [radio_task_event_properties.sv]
// Checker for the radio task and event bank, bound to its top module.
// Assumes zero-wait APB and one-cycle task pulses after the write edge.
`timescale 1ns/1ns
`default_nettype none
`include "radio_task_event_defines.svh"

module radio_task_event_properties
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Tasks and state
    input wire logic        radio_start,
    input wire logic        radio_stop,
    input wire logic        radio_disable,
    input wire logic        strength_sample_start,
    input wire logic        strength_sample_stop,
    input wire logic        bit_counter_start,
    input wire logic        bit_counter_stop,
    input wire logic        radio_enabled,
    input wire logic        radio_running,
    input wire logic        sampling_busy,
    input wire logic        bit_counter_running
);
    logic [11:0] wa;
    // Address of a completed write with bit 0 set, else an unmapped value
    assign wa = (psel && penable && pready && pwrite && pwdata[0]) ? paddr : 12'hfff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_stop_halts: assert property (wa == `RTE_OFF_STOP |=> radio_stop ##1 !radio_running)
        else $error("stop not applied");
    a_disable_off: assert property (wa == `RTE_OFF_DISABLE |=> radio_disable ##1
        (!radio_enabled && !sampling_busy && !bit_counter_running))
        else $error("disable not applied");
    a_sample_once: assert property (wa == `RTE_OFF_SAMPLE_START && !sampling_busy
        |=> strength_sample_start ##1 sampling_busy) else $error("sample not started");
    a_sample_stop: assert property (wa == `RTE_OFF_SAMPLE_STOP && sampling_busy
        |=> strength_sample_stop ##1 !sampling_busy) else $error("sample not stopped");
    a_count_start: assert property (wa == `RTE_OFF_BC_START
        |=> bit_counter_start ##1 bit_counter_running) else $error("counter not started");
    a_count_stop: assert property (wa == `RTE_OFF_BC_STOP
        |=> bit_counter_stop ##1 !bit_counter_running) else $error("counter not stopped");
    a_start_ramped: assert property (wa == `RTE_OFF_START && radio_enabled && !radio_running
        |=> radio_start ##1 radio_running) else $error("start not applied");
    a_start_early: assert property (wa == `RTE_OFF_START && !radio_enabled
        |=> !radio_start [*2]) else $error("start before ramp-up");
endmodule : radio_task_event_properties

bind radio_task_event_registers radio_task_event_properties u_radio_task_event_properties
(
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .radio_start(radio_start),
    .radio_stop(radio_stop), .radio_disable(radio_disable),
    .strength_sample_start(strength_sample_start), .strength_sample_stop(strength_sample_stop),
    .bit_counter_start(bit_counter_start), .bit_counter_stop(bit_counter_stop),
    .radio_enabled(radio_enabled), .radio_running(radio_running),
    .sampling_busy(sampling_busy), .bit_counter_running(bit_counter_running)
);
`default_nettype wire

// [radio_core_model.sv]
// Behavioural radio core: ramp-up, packet phases and one strength sample.
// Assumes one-cycle task pulses from the bank on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module radio_core_model
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Commands
    input  wire logic ramp_cmd,
    input  wire logic radio_start,
    input  wire logic radio_stop,
    input  wire logic radio_disable,
    input  wire logic strength_sample_start,
    input  wire logic strength_sample_stop,
    // Events
    output var  logic core_ramp_done,
    output var  logic core_address,
    output var  logic core_payload,
    output var  logic core_packet_done,
    output var  logic core_sample_done
);
    logic [2:0] rp;
    logic [4:0] pk;
    logic [3:0] sm;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {rp, pk, sm} <= '0;
            {core_ramp_done, core_address, core_payload} <= '0;
            {core_packet_done, core_sample_done} <= '0;
        end
        else
        begin
            rp <= ramp_cmd ? 3'h4 : (rp != 0 ? rp - 3'h1 : 3'h0);
            core_ramp_done <= (rp == 3'h1);
            pk <= (radio_stop || radio_disable || pk == 5'h16) ? 5'h0 :
                  (radio_start ? 5'h1 : (pk != 0 ? pk + 5'h1 : 5'h0));
            core_address <= (pk == 5'h0a);
            core_payload <= (pk == 5'h10);
            core_packet_done <= (pk == 5'h16);
            sm <= (strength_sample_stop || radio_disable || sm == 4'h8) ? 4'h0 :
                  (strength_sample_start ? 4'h1 : (sm != 0 ? sm + 4'h1 : 4'h0));
            core_sample_done <= (sm == 4'h8);
        end
    end
endmodule : radio_core_model
`default_nettype wire

// [tb_radio_task_event_registers.sv]
// Testbench of the radio task and event bank over APB.
// Assumes the core model answers tasks with fixed event spacing.
`timescale 1ns/1ns
`default_nettype none
`include "radio_task_event_defines.svh"

module tb_radio_task_event_registers;
    logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ramp_cmd = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [6:0]  ic = '0;
    logic        pready, pslverr, e, irq, r_st, r_sp, r_ds, s_st, s_sp;
    logic        c_rd, c_ad, c_pl, c_pd, c_sd, en, run, smp, cnt;
    int          bad_count = 0, checked = 0, cyc = 0;
    logic [3:0]  ex [7] = '{4'h9, 4'h8, 4'hc, 4'h8, 4'ha, 4'h8, 4'h0};
    int          ix [7] = '{5, 6, 0, 1, 3, 4, 2};

    radio_task_event_registers u_radio_task_event_registers (.sys_clk(sys_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ic_start(ic[0]),
        .ic_stop(ic[1]), .ic_disable(ic[2]), .ic_sample_start(ic[3]),
        .ic_sample_stop(ic[4]), .ic_bc_start(ic[5]), .ic_bc_stop(ic[6]),
        .core_ramp_done(c_rd), .core_address(c_ad), .core_payload(c_pl),
        .core_packet_done(c_pd), .core_sample_done(c_sd), .radio_start(r_st),
        .radio_stop(r_sp), .radio_disable(r_ds), .strength_sample_start(s_st),
        .strength_sample_stop(s_sp), .bit_counter_start(), .bit_counter_stop(),
        .radio_enabled(en), .radio_running(run), .sampling_busy(smp),
        .bit_counter_running(cnt), .irq(irq));
    radio_core_model u_radio_core_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .ramp_cmd(ramp_cmd), .radio_start(r_st), .radio_stop(r_sp), .radio_disable(r_ds),
        .strength_sample_start(s_st), .strength_sample_stop(s_sp), .core_ramp_done(c_rd),
        .core_address(c_ad), .core_payload(c_pl), .core_packet_done(c_pd),
        .core_sample_done(c_sd));

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    task final_report;
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            final_report();
        end
    end

    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    // Waits for pready with no limit of its own; the cycle ceiling ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        penable <= 1;
        do
        begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk("read", q, x);
    endtask : rdc

    task st(input logic [3:0] x);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("state", {28'h0, en, run, smp, cnt}, {28'h0, x});
    endtask : st

    task ramp;
        @(posedge sys_clk) ramp_cmd <= 1;
        @(posedge sys_clk) ramp_cmd <= 0;
        repeat (8) @(posedge sys_clk);
    endtask : ramp

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1;
        for (int i = 0; i < 4; i++) rdc(12'h100 + 12'(4 * i), 0);
        rdc(`RTE_OFF_STOP, 0);
        apb(0, 12'h0f0, 0);
        chk("unmapped", 32'(e), 1);
        apb(1, `RTE_OFF_START, 1);
        st(4'h0);
        apb(1, `RTE_OFF_IRQ_MASK, 32'hf);
        rdc(`RTE_OFF_IRQ_MASK, 32'hf);
        ramp();
        rdc(`RTE_OFF_RAMP_DONE, 1);
        chk("irq", 32'(irq), 1);
        apb(1, `RTE_OFF_IRQ_STATUS, 1);
        // The clear lands on the access edge and irq drops on that same edge; it is sampled one edge later
        @(posedge sys_clk);
        chk("irq", 32'(irq), 0);
        apb(1, `RTE_OFF_IRQ_MASK, 0);
        apb(1, `RTE_OFF_START, 1);
        st(4'hc);
        repeat (30) @(posedge sys_clk);
        st(4'h8);
        for (int i = 1; i < 4; i++) rdc(12'h100 + 12'(4 * i), 1);
        chk("irq", 32'(irq), 0);
        rdc(`RTE_OFF_IRQ_STATUS, 32'he);
        apb(1, `RTE_OFF_IRQ_STATUS, 32'he);
        rdc(`RTE_OFF_IRQ_STATUS, 0);
        for (int i = 0; i < 4; i++) apb(1, 12'h100 + 12'(4 * i), 0);
        for (int i = 0; i < 4; i++) rdc(12'h100 + 12'(4 * i), 0);
        apb(1, `RTE_OFF_START, 1);
        apb(1, `RTE_OFF_STOP, 1);
        st(4'h8);
        repeat (30) @(posedge sys_clk);
        rdc(`RTE_OFF_ADDRESS, 0);
        apb(1, `RTE_OFF_SAMPLE_START, 1);
        st(4'ha);
        repeat (10) @(posedge sys_clk);
        st(4'h8);
        apb(1, `RTE_OFF_SAMPLE_START, 1);
        apb(1, `RTE_OFF_SAMPLE_STOP, 1);
        st(4'h8);
        apb(1, `RTE_OFF_BC_START, 1);
        st(4'h9);
        rdc(`RTE_OFF_CORE_STATE, 32'h9);
        apb(1, `RTE_OFF_BC_STOP, 1);
        st(4'h8);
        apb(1, `RTE_OFF_START, 1);
        apb(1, `RTE_OFF_BC_START, 1);
        apb(1, `RTE_OFF_SAMPLE_START, 1);
        apb(1, `RTE_OFF_DISABLE, 1);
        st(4'h0);
        ramp();
        for (int i = 0; i < 7; i++)
        begin
            @(posedge sys_clk) ic[ix[i]] <= 1;
            @(posedge sys_clk) ic[ix[i]] <= 0;
            st(ex[i]);
        end
        final_report();
    end
endmodule : tb_radio_task_event_registers
`default_nettype wire
